// *** hdl/rst_seq_pkg.sv ***
// shared constants and carriers for the reset-cause and power-on sequencer
// assumes a single 125 MHz clock domain
package rst_seq_pkg;
    localparam int CLK_MHZ = 125;
    // register indexes (byte-wide regs on a plain port)
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_EXT = 2'h1;
    localparam logic [1:0] ADDR_SUPPLY = 2'h2;
    localparam logic [1:0] ADDR_SLEEP = 2'h3;
    // reset_status_control fields
    localparam int B_INTERRUPT_PRIORITY_ENABLE = 7;
    localparam int B_CMF = 5;
    localparam int B_RIF = 4;
    localparam int B_WTO = 3;
    localparam int B_PDF = 2;
    localparam int B_PWON = 1;
    localparam int B_BRN = 0;
    localparam logic [7:0] CTRL_WMASK = 8'hB3;
    localparam logic [7:0] CTRL_RST = 8'h3C;
    // reset_status_ext fields
    localparam int B_EXTP = 7;
    localparam int B_SWDT = 5;
    localparam logic [7:0] EXT_WMASK = 8'hA0;
    // reset_status_supply fields
    localparam int B_SBRN = 3;
    localparam int B_SPOR = 2;
    localparam int B_BPOR = 1;
    localparam int B_BEXIT = 0;
    localparam logic [7:0] SUP_WMASK = 8'h0F;
    // reset_status_sleep fields
    localparam int B_DSW = 2;
    localparam int B_PMSP = 0;
    localparam logic [7:0] SLP_WMASK = 8'h05;
    localparam logic [1:0] WDT_CFG_SOFT = 2'h2;
    // sequencer times in ns
    localparam int T_BIAS_NS = 10000;
    localparam int T_PWRUP_NS = 64000;
    localparam int T_OSC_NS = 8000;
    localparam int BIAS_CYC = (T_BIAS_NS * CLK_MHZ + 999) / 1000;
    localparam int PWRUP_CYC = (T_PWRUP_NS * CLK_MHZ + 999) / 1000;
    localparam int OSC_CYC = (T_OSC_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 16;

    typedef enum logic [3:0] {
        ST_BIAS = 4'b0001,
        ST_PWRUP = 4'b0010,
        ST_OSC = 4'b0100,
        ST_RUN = 4'b1000
    } seq_state_e;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic master_clear_pin;
        logic wdt_timeout;
        logic reset_instr;
        logic cfg_mismatch;
        logic core_brownout;
        logic supply_brownout;
        logic clear_watchdog_instruction;
        logic sleep;
        logic deep_wake;
    } evt_s;
endpackage : rst_seq_pkg

// *** hdl/sync_2ff.sv ***
// two-flop level synchroniser, one bit per lane
// assumes inputs may change at any time relative to the clock
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
    parameter int W = 1
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta <= '0;
            q_out <= '0;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule : sync_2ff
`default_nettype wire

// *** hdl/delay_timer.sv ***
// loadable down-counter, done pulses when it reaches zero
// assumes load and run are not both high
`timescale 1ns/100ps
`default_nettype none
module delay_timer #(
    parameter int W = 16
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic load_in,
    input wire logic [W-1:0] count_in,
    input wire logic run_in,
    output logic done_out
);
    logic [W-1:0] cnt;
    wire logic last = (cnt == W'(1));
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt <= '0;
            done_out <= 1'b0;
        end else begin
            done_out <= run_in && last;
            if (load_in) begin
                cnt <= count_in;
            end else if (run_in && cnt != '0) begin
                cnt <= cnt - W'(1);
            end
        end
    end
endmodule : delay_timer
`default_nettype wire

// *** hdl/rst_seq.sv ***
// reset-cause tracking and power-on sequencing top
// assumes synchronous register port, async power/reset event inputs
//
// Operation
// - writing any status flag only stores it, never starts a reset
// - control register bit 7 is read/write priority enable, resets to 0
// - mismatch reset clears bit 5; software writes it back to 1
// - reset-instruction flag reads 1 after power-up, 0 after instruction
// - read-only timeout flag set by power-up, clear-watchdog, sleep
// - read-only powerdown flag set by power-up or clear-watchdog, cleared by sleep
// - power-on clears power-on and brownout flags; only software sets them
// - pin reset sets external flag; resets to 0; software may clear
// - soft watchdog enable acts only when config field equals 10
// - supply brownout reset sets flag; software clears; resets to 0
// - supply power-on sets flag; software clears it afterwards
// - power-on in battery mode sets its flag; rest to power-on state
// - supply return sets exit flag; rest reset except semaphores
// - battery mode holds reset, runs no code, skips power-up delay
// - deep-sleep wake flag set only by hardware, cleared only by software; power-on and supply return also clear it here
// - program-memory sleep power bit keeps memory powered in sleep
// - power-on pulse resets timer, enters reset, selects configured clock
// - bias delay then power-up delay with execution disabled
// - clock start-up delay, then release reset and system clock
// - pin reset asserts system reset, keeps clock, sets external flag
// - watchdog timeout clears timeout flag
// - reset instruction clears reset-instruction flag
// - configuration mismatch starts a reset and clears its flag
`timescale 1ns/100ps
`default_nettype none
module rst_seq
    import rst_seq_pkg::*;
#(
    parameter int BIAS_CYCLES = BIAS_CYC,
    parameter int PWRUP_CYCLES = PWRUP_CYC,
    parameter int OSC_CYCLES = OSC_CYC
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic por_pulse_in,
    input wire logic battery_mode_in,
    input wire logic [1:0] osc_config_in,
    input wire logic [1:0] watchdog_config_field_in,
    input wire evt_s evt_in,
    input wire reg_req_s req_in,
    output logic [7:0] rdata_out,
    output logic system_reset_out,
    output logic clock_release_out,
    output logic [1:0] clock_select_out,
    output logic watchdog_enable_out,
    output logic interrupt_priority_enable_out,
    output logic progmem_sleep_power_out
);
    // ---------------------------------------------------------------
    // event synchronisation
    // ---------------------------------------------------------------
    evt_s ev;
    evt_s ev_d;
    logic bat_s;
    logic bat_d;
    sync_2ff #(.W($bits(evt_s) + 1)) u_sync (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .d_in({evt_in, battery_mode_in}),
        .q_out({ev, bat_s})
    );
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ev_d <= '0;
            bat_d <= 1'b0;
        end else begin
            ev_d <= ev;
            bat_d <= bat_s;
        end
    end
    // rising edges of the synchronised event levels
    wire evt_s rise = ev & ~ev_d;
    wire logic bat_exit = bat_d & ~bat_s;

    // ---------------------------------------------------------------
    // power-on sequencer
    // ---------------------------------------------------------------
    // the power-on pulse doubles as an async clear so no clock is needed
    wire logic arst_n = arst_n_in & ~por_pulse_in;
    // first cycle after power-on: flags take their power-on state
    logic por_first;
    seq_state_e state;
    seq_state_e next_state;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_count;
    logic tmr_done;
    logic tmr_armed;
    always_ff @(posedge sys_clk_in or negedge arst_n) begin
        if (!arst_n) begin
            por_first <= 1'b1;
        end else begin
            por_first <= 1'b0;
        end
    end
    // battery mode keeps the core parked with timers reloaded
    wire logic hold_bat = bat_s;
    always_comb begin
        next_state = state;
        unique case (state)
            ST_BIAS: begin
                if (tmr_done && tmr_armed) next_state = ST_PWRUP;
            end
            ST_PWRUP: begin
                if (tmr_done && tmr_armed) next_state = ST_OSC;
            end
            ST_OSC: begin
                if (tmr_done && tmr_armed) next_state = ST_RUN;
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
        endcase
        if (hold_bat) next_state = ST_BIAS;
        // no power-up delay after battery power-on ends
        if (bat_exit && state == ST_BIAS) next_state = ST_OSC;
    end
    assign tmr_load = !tmr_armed || (next_state != state);
    assign tmr_count = (next_state == ST_BIAS) ? CNT_W'(BIAS_CYCLES) :
                       (next_state == ST_PWRUP) ? CNT_W'(PWRUP_CYCLES) : CNT_W'(OSC_CYCLES);
    delay_timer #(.W(CNT_W)) u_tmr (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n),
        .load_in(tmr_load),
        .count_in(tmr_count),
        .run_in(!tmr_load && state != ST_RUN && !hold_bat),
        .done_out(tmr_done)
    );
    always_ff @(posedge sys_clk_in or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_BIAS;
            tmr_armed <= 1'b0;
        end else begin
            state <= next_state;
            tmr_armed <= !hold_bat;
        end
    end

    // warm resets: sources that restart code but keep the clock
    wire logic warm_async = evt_in.master_clear_pin | evt_in.wdt_timeout | evt_in.reset_instr | evt_in.cfg_mismatch
                            | evt_in.core_brownout | evt_in.supply_brownout;
    // only reset sources stretch the reset; sleep, clear-watchdog and wake must not
    wire logic ev_warm = ev.master_clear_pin | ev.wdt_timeout | ev.reset_instr | ev.cfg_mismatch | ev.core_brownout
                         | ev.supply_brownout;
    always_ff @(posedge sys_clk_in or negedge arst_n or posedge warm_async) begin
        if (!arst_n) begin
            system_reset_out <= 1'b1;
            clock_release_out <= 1'b0;
        end else if (warm_async) begin
            system_reset_out <= 1'b1;
            clock_release_out <= 1'b1;
        end else begin
            system_reset_out <= (next_state != ST_RUN) | ev_warm;
            clock_release_out <= (next_state == ST_RUN) | (state == ST_RUN);
        end
    end
    // configured clock captured on power-on, kept across warm resets
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            clock_select_out <= 2'h0;
        end else if (por_first) begin
            clock_select_out <= osc_config_in;
        end
    end

    // ---------------------------------------------------------------
    // status and control registers
    // ---------------------------------------------------------------
    logic [7:0] ctrl;
    logic [7:0] ext;
    logic [7:0] sup;
    logic [7:0] slp;
    wire logic wr_ctrl = req_in.wr && req_in.addr == ADDR_CTRL;
    wire logic wr_ext = req_in.wr && req_in.addr == ADDR_EXT;
    wire logic wr_sup = req_in.wr && req_in.addr == ADDR_SUPPLY;
    wire logic wr_slp = req_in.wr && req_in.addr == ADDR_SLEEP;
    // writes only merge into storage, never into the reset path
    wire logic [7:0] next_ctrl_sw = wr_ctrl ? ((ctrl & ~CTRL_WMASK) | (req_in.wdata & CTRL_WMASK)) : ctrl;
    wire logic [7:0] next_ext_sw = wr_ext ? (req_in.wdata & EXT_WMASK) : ext;
    // supply flags are clear-only from software
    wire logic [7:0] next_sup_sw = wr_sup ? (sup & req_in.wdata & SUP_WMASK) : sup;
    wire logic [7:0] next_slp_sw = wr_slp ? ((slp & req_in.wdata & 8'h04) | (req_in.wdata & 8'h01)) : slp;
    logic [7:0] next_ctrl;
    logic [7:0] next_ext;
    logic [7:0] next_sup;
    logic [7:0] next_slp;
    always_comb begin
        next_ctrl = next_ctrl_sw;
        next_ext = next_ext_sw;
        next_sup = next_sup_sw;
        next_slp = next_slp_sw;
        if (rise.cfg_mismatch) next_ctrl[B_CMF] = 1'b0;
        if (rise.reset_instr) next_ctrl[B_RIF] = 1'b0;
        if (rise.clear_watchdog_instruction) begin
            next_ctrl[B_WTO] = 1'b1;
            next_ctrl[B_PDF] = 1'b1;
        end
        if (rise.sleep) begin
            next_ctrl[B_WTO] = 1'b1;
            next_ctrl[B_PDF] = 1'b0;
        end
        if (rise.wdt_timeout) next_ctrl[B_WTO] = 1'b0;
        if (rise.master_clear_pin) next_ext[B_EXTP] = 1'b1;
        if (rise.supply_brownout) next_sup[B_SBRN] = 1'b1;
        if (rise.deep_wake) next_slp[B_DSW] = 1'b1;
        if (bat_exit) begin
            next_ctrl = CTRL_RST;
            next_ext = 8'h00;
            next_slp = 8'h00;
            next_sup[B_BEXIT] = 1'b1;
        end
        if (por_first) begin
            next_ctrl = CTRL_RST;
            next_ext = 8'h00;
            next_slp = 8'h00;
            next_sup = 8'h00;
            next_sup[B_SPOR] = 1'b1;
            next_sup[B_BPOR] = bat_s;
        end
    end
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl <= CTRL_RST;
            ext <= 8'h00;
            sup <= 8'h00;
            slp <= 8'h00;
        end else begin
            ctrl <= next_ctrl;
            ext <= next_ext;
            sup <= next_sup;
            slp <= next_slp;
        end
    end

    // ---------------------------------------------------------------
    // read port and control outputs
    // ---------------------------------------------------------------
    wire logic [7:0] rd_mux = (req_in.addr == ADDR_CTRL) ? ctrl :
                              (req_in.addr == ADDR_EXT) ? ext :
                              (req_in.addr == ADDR_SUPPLY) ? sup : slp;
    wire logic wdt_on = (watchdog_config_field_in == WDT_CFG_SOFT) && next_ext[B_SWDT];
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out <= 8'h00;
            watchdog_enable_out <= 1'b0;
            interrupt_priority_enable_out <= 1'b0;
            progmem_sleep_power_out <= 1'b0;
        end else begin
            rdata_out <= req_in.rd ? rd_mux : 8'h00;
            watchdog_enable_out <= wdt_on;
            interrupt_priority_enable_out <= next_ctrl[B_INTERRUPT_PRIORITY_ENABLE];
            progmem_sleep_power_out <= next_slp[B_PMSP];
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_write_no_reset: assert property (@(posedge sys_clk_in) disable iff (!arst_n)
        (state == ST_RUN && req_in.wr && !(|ev) && !warm_async) |=> !system_reset_out)
        else $error("register write caused reset");
    a_pmsp_follows: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (wr_slp && !por_first) |=> progmem_sleep_power_out == $past(req_in.wdata[B_PMSP]))
        else $error("program memory power bit wrong");
    a_interrupt_priority_enable_write: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (wr_ctrl && !por_first && !bat_exit) |=> ctrl[B_INTERRUPT_PRIORITY_ENABLE] == $past(req_in.wdata[B_INTERRUPT_PRIORITY_ENABLE]))
        else $error("priority enable not stored");
    a_sleep_pd: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (rise.sleep && !rise.clear_watchdog_instruction && !por_first && !bat_exit) |=> !ctrl[B_PDF])
        else $error("sleep did not clear powerdown flag");
    a_wdt_to: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (rise.wdt_timeout && !por_first && !bat_exit) |=> !ctrl[B_WTO])
        else $error("timeout did not clear flag");
    a_master_clear_pin_external_pin_reset_flag: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (rise.master_clear_pin && !por_first && !bat_exit) |=> ext[B_EXTP])
        else $error("pin reset flag not set");
    a_cm_flag: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (rise.cfg_mismatch && !por_first && !bat_exit) |=> !ctrl[B_CMF])
        else $error("mismatch flag not cleared");
    a_ri_flag: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (rise.reset_instr && !por_first && !bat_exit) |=> !ctrl[B_RIF])
        else $error("reset instruction flag not cleared");
    a_unimpl_zero: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        ctrl[6] == 1'b0 && sup[7:4] == 4'h0 && slp[7:3] == 5'h0 && ext[4:0] == 5'h0)
        else $error("unimplemented bit nonzero");
    a_wdt_gate: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (watchdog_config_field_in != WDT_CFG_SOFT) |=> !watchdog_enable_out)
        else $error("watchdog enabled outside soft mode");

    // ---------------------------------------------------------------
    // sequencer and flag checks
    // ---------------------------------------------------------------
    a_clear_watchdog_instruction_flags: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (rise.clear_watchdog_instruction && !rise.sleep && !rise.wdt_timeout && !por_first && !bat_exit) |=> ctrl[B_WTO] && ctrl[B_PDF])
        else $error("clear-watchdog did not set flags");
    a_sleep_wto: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (rise.sleep && !rise.wdt_timeout && !por_first) |=> ctrl[B_WTO])
        else $error("sleep did not set timeout flag");
    a_supply_brn: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (rise.supply_brownout && !por_first) |=> sup[B_SBRN])
        else $error("supply brownout flag not set");
    a_deep_wake: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (rise.deep_wake && !por_first && !bat_exit) |=> slp[B_DSW])
        else $error("deep-sleep wake flag not set");
    a_dsw_hw_only: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (!rise.deep_wake && !slp[B_DSW]) |=> !slp[B_DSW])
        else $error("deep-sleep wake flag set without wake");
    a_por_state: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        por_first |=> ctrl == CTRL_RST && ext == 8'h00 && slp == 8'h00 && sup[B_SPOR] && sup[B_BPOR] == $past(bat_s))
        else $error("power-on register state wrong");
    a_bat_exit: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (bat_exit && !por_first) |=> sup[B_BEXIT] && ctrl == CTRL_RST && ext == 8'h00 && slp == 8'h00)
        else $error("battery exit state wrong");
    a_bat_hold: assert property (@(posedge sys_clk_in) disable iff (!arst_n)
        (hold_bat && state != ST_RUN && !warm_async) |=> system_reset_out && !clock_release_out)
        else $error("battery mode released the core");
    a_bat_skip: assert property (@(posedge sys_clk_in) disable iff (!arst_n)
        (bat_exit && state == ST_BIAS) |=> state == ST_OSC)
        else $error("battery exit did not skip power-up delay");
    a_bias_first: assert property (@(posedge sys_clk_in) disable iff (!arst_n)
        (state == ST_BIAS && !bat_exit) |=> state != ST_OSC && state != ST_RUN)
        else $error("bias delay skipped");
    a_osc_before_run: assert property (@(posedge sys_clk_in) disable iff (!arst_n)
        (state != ST_OSC && state != ST_RUN) |=> state != ST_RUN)
        else $error("clock start-up delay skipped");
    a_release_run: assert property (@(posedge sys_clk_in) disable iff (!arst_n)
        !system_reset_out |-> state == ST_RUN && clock_release_out)
        else $error("reset released before sequence end");
    a_clock_kept: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        !por_first |=> $stable(clock_select_out))
        else $error("clock source changed without power-on");
    a_clock_cap: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        por_first |=> clock_select_out == $past(osc_config_in))
        else $error("configured clock not selected");
    a_warm_reset: assert property (@(posedge sys_clk_in) disable iff (!arst_n)
        warm_async |-> system_reset_out)
        else $error("reset source did not assert reset");
    a_ext_write: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        (wr_ext && !por_first && !bat_exit && !rise.master_clear_pin) |=> ext == ($past(req_in.wdata) & EXT_WMASK))
        else $error("external status write wrong");
endmodule : rst_seq
`default_nettype wire

// *** verification/rst_seq_src.sv ***
// behavioural supply monitors, reset sources and core events feeding rst_seq
// assumes the bench calls its tasks at a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module rst_seq_src
    import rst_seq_pkg::*;
(
    input wire logic sys_clk_in,
    output var evt_s evt_out,
    output logic por_out,
    output logic batt_out
);
    initial begin
        evt_out = '0;
        por_out = 1'b0;
        batt_out = 1'b0;
    end

    // ----------------------------------------
    // event sources
    // ----------------------------------------
    // hold length varies so slow and prompt sources are both seen
    task automatic pulse(input int k, input int len);
        @(posedge sys_clk_in);
        evt_out[k] <= 1'b1;
        repeat (len) @(posedge sys_clk_in);
        evt_out[k] <= 1'b0;
    endtask : pulse

    task automatic power_on(input logic b);
        @(posedge sys_clk_in);
        por_out <= 1'b1;
        batt_out <= b;
        repeat (3) @(posedge sys_clk_in);
        por_out <= 1'b0;
    endtask : power_on

    // main supply comes back
    task automatic leave_batt();
        @(posedge sys_clk_in);
        batt_out <= 1'b0;
    endtask : leave_batt
endmodule : rst_seq_src
`default_nettype wire

// *** verification/rst_seq_tb_top.sv ***
// self-checking bench for rst_seq with a queued read scoreboard
// assumes rst_seq_src drives power and event inputs
`timescale 1ns/100ps
`default_nettype none
module rst_seq_tb_top;
    import rst_seq_pkg::*;
    localparam int BC = 6;
    localparam int PC = 12;
    localparam int OC = 5;
    localparam int ORD [8] = '{1, 7, 2, 6, 5, 8, 3, 0};
    logic sys_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [1:0] osc_cfg = 2'h0;
    logic [1:0] wcfg = 2'h0;
    reg_req_s req = '0;
    evt_s evt;
    logic por, batt, sys_rst, clk_rel, wdt_en, interrupt_priority_enable, pm, rd_pend;
    logic [1:0] clk_sel;
    logic [7:0] rdata;
    logic [7:0] e [4];
    logic [7:0] wm [4];
    logic [7:0] exp_q [$];
    int error_cnt = 0;
    int total_checks = 0;
    int seed = 46325;
    int n;
    int k;

    always #4 sys_clk_in = ~sys_clk_in;

    rst_seq #(.BIAS_CYCLES(BC), .PWRUP_CYCLES(PC), .OSC_CYCLES(OC)) dut (
        .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .por_pulse_in(por),
        .battery_mode_in(batt), .osc_config_in(osc_cfg), .watchdog_config_field_in(wcfg),
        .evt_in(evt), .req_in(req), .rdata_out(rdata), .system_reset_out(sys_rst),
        .clock_release_out(clk_rel), .clock_select_out(clk_sel), .watchdog_enable_out(wdt_en),
        .interrupt_priority_enable_out(interrupt_priority_enable), .progmem_sleep_power_out(pm)
    );

    rst_seq_src src (.sys_clk_in(sys_clk_in), .evt_out(evt), .por_out(por), .batt_out(batt));

    // ----------------------------------------
    // checking
    // ----------------------------------------
    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        total_checks++;
        if (s !== x) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk

    task automatic give_verdict();
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // read data stands only in the cycle after the strobe
    initial rd_pend = 1'b0;
    always @(posedge sys_clk_in) begin
        if (rd_pend) chk(rdata, exp_q.pop_front());
        rd_pend <= req.rd;
    end

    // ----------------------------------------
    // register port and sequencer helpers
    // ----------------------------------------
    task automatic rw(input logic [1:0] a, input logic [7:0] d, input logic w);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: d, wr: w, rd: ~w};
        if (!w) exp_q.push_back(e[a]);
        else if (a == ADDR_SUPPLY) e[a] = e[a] & (d | 8'hF0);
        else if (a == ADDR_SLEEP) e[a] = {5'h00, e[a][2] & d[2], 1'b0, d[0]};
        else e[a] = (d & wm[a]) | (e[a] & ~wm[a]);
        @(posedge sys_clk_in);
        req <= '0;
    endtask : rw

    task automatic read_all();
        for (int a = 0; a < 4; a++) rw(2'(a), 8'h00, 1'b0);
    endtask : read_all

    task automatic wait_rel(output int c);
        c = 0;
        while (sys_rst !== 1'b0 && c < 3000) begin
            @(negedge sys_clk_in);
            c++;
        end
        if (c >= 3000) begin
            error_cnt++;
            give_verdict();
        end
    endtask : wait_rel

    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        wm = '{CTRL_WMASK, EXT_WMASK, SUP_WMASK, SLP_WMASK};
        e = '{CTRL_RST, 8'h00, 8'h04, 8'h00};
        osc_cfg = 2'($random(seed));
        repeat (20) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        wait_rel(n);
        @(negedge sys_clk_in);
        chk(n >= BC + PC + OC && n <= BC + PC + OC + 12, 1);
        chk(clk_rel, 1);
        chk(clk_sel, osc_cfg);
        read_all();
        foreach (ORD[i]) begin
            k = ORD[i];
            fork
                src.pulse(k, 3 + i);
                begin
                    repeat (4) @(posedge sys_clk_in);
                    @(negedge sys_clk_in);
                    chk(sys_rst, k >= 3);
                end
            join
            case (k)
                8: e[1][7] = 1'b1;
                7: e[0][3] = 1'b0;
                6: e[0][4] = 1'b0;
                5: e[0][5] = 1'b0;
                3: e[2][3] = 1'b1;
                2: e[0][3:2] = 2'b11;
                1: e[0][3:2] = 2'b10;
                default: e[3][2] = 1'b1;
            endcase
            wait_rel(n);
            read_all();
        end
        repeat (12) begin
            wcfg <= 2'($random(seed));
            k = $random(seed);
            rw(2'(k), 8'($random(seed)), 1'b1);
            @(negedge sys_clk_in);
            chk(sys_rst, 0);
            chk(wdt_en, wcfg == WDT_CFG_SOFT && e[1][5]);
            chk(interrupt_priority_enable, e[0][7]);
            chk(pm, e[3][0]);
            rw(2'(k), 8'h00, 1'b0);
        end
        wcfg <= WDT_CFG_SOFT;
        for (int v = 0; v < 2; v++) begin
            rw(ADDR_CTRL, {v[0], 7'h7F}, 1'b1);
            rw(ADDR_EXT, {2'h0, v[0], 5'h1F}, 1'b1);
            rw(ADDR_SLEEP, {7'h7F, v[0]}, 1'b1);
            repeat (2) @(negedge sys_clk_in);
            chk(interrupt_priority_enable, v[0]);
            chk(wdt_en, v[0]);
            chk(pm, v[0]);
            read_all();
        end
        rw(ADDR_CTRL, 8'hFF, 1'b1);
        osc_cfg <= 2'($random(seed));
        e = '{CTRL_RST, 8'h00, 8'h06, 8'h00};
        src.power_on(1'b1);
        @(negedge sys_clk_in);
        chk(sys_rst, 1);
        repeat (BC + PC + OC + 20) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk(sys_rst, 1);
        chk(clk_rel, 0);
        chk(interrupt_priority_enable, 0);
        read_all();
        src.leave_batt();
        e[2][0] = 1'b1;
        wait_rel(n);
        @(negedge sys_clk_in);
        chk(n < BC + PC + OC, 1);
        chk(clk_sel, osc_cfg);
        read_all();
        repeat (4) @(posedge sys_clk_in);
        give_verdict();
    end
endmodule : rst_seq_tb_top
`default_nettype wire
